// File: hdl/dcirq_code_decode.v
// completion code capture and decode to a one-hot pending request
`timescale 1ns/10ps
`default_nettype none
`include "dcirq_defs.vh"
module dcirq_code_decode (
  input wire clk,
  input wire srst,
  input wire ce,
  input wire code_valid,
  input wire final_irq_en,
  input wire inter_irq_en,
  input wire is_final,
  input wire [`DCIRQ_CODE_W-1:0] code,
  output reg [`DCIRQ_NCHAN-1:0] set_req_q,
  output reg out_of_range_q
);
  // code must be returned only when the matching option enable is on
  wire ret_en;
  assign ret_en = code_valid & (is_final ? final_irq_en : inter_irq_en);

  // one-hot decode; codes 32 and up do not reach the pending bits
  genvar g;
  generate
    for (g = 0; g < `DCIRQ_NCHAN; g = g + 1)
    begin : g_dec
      always @(posedge clk)
      begin
        if (srst)
          set_req_q[g] <= 1'b0;
        else if (ce)
          // zero-extend the code so codes 32 and up can never alias a low channel
          set_req_q[g] <= ret_en && ({{(32-`DCIRQ_CODE_W){1'b0}}, code} == g);
      end
    end
  endgenerate

  // flag codes that fall outside the pending range
  always @(posedge clk)
  begin
    if (srst)
      out_of_range_q <= 1'b0;
    else if (ce)
      out_of_range_q <= ret_en && code[`DCIRQ_CODE_W-1];
  end
endmodule // dcirq_code_decode
`default_nettype wire

// File: hdl/dcirq_top.v
// dma completion interrupt unit: pending, enable, region irq and reevaluate
//
// Summary of operation
// - a one written to enable-set sets the enable bit; zeros change nothing
// - a code is returned only when final or intermediate irq enable is on
// - returned code equals the option word's completion code field
// - code n in 0..31 sets pending bit n
// - pending bits stay set until software clears them
// - a one written to pending-clear clears that pending bit; zeros do nothing
// - no further completion pulse until all pending bits have been cleared
// - reevaluate bit 0 pulses the irq again if enabled pending bits remain
// - a shadow reevaluate pulses its own region's irq, the global copy pulses both region irqs
// - reevaluate exists in global and each shadow region, never access gated
// - the enable mask is not directly writable, only via set and clear
// - a one written to enable-clear clears that enable bit
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "dcirq_defs.vh"
module dcirq_top (
  input wire clk,
  input wire srst,
  input wire ce,
  input wire [`DCIRQ_ADDR_W-1:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata_q,
  input wire code_valid,
  input wire [`DCIRQ_CODE_W-1:0] code,
  input wire is_final,
  input wire final_irq_en,
  input wire inter_irq_en,
  output reg [`DCIRQ_NREG-1:0] region_irq_q,
  output reg irq_q
);
  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT = 2'b10;

  wire [`DCIRQ_NCHAN-1:0] set_req;
  wire out_of_range;

  // the decoder adds one cycle between code arrival and the pending bit
  dcirq_code_decode u_dec (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .code_valid(code_valid),
    .final_irq_en(final_irq_en),
    .inter_irq_en(inter_irq_en),
    .is_final(is_final),
    .code(code),
    .set_req_q(set_req),
    .out_of_range_q(out_of_range)
  );

  reg [31:0] enable_q;
  reg [31:0] pending_q;
  reg [31:0] map_q [0:`DCIRQ_NREG-1];
  reg [`DCIRQ_EV_W-1:0] status_q;
  reg [`DCIRQ_EV_W-1:0] mask_q;
  reg [1:0] state_q [0:`DCIRQ_NREG-1];
  reg [31:0] rdata_d;

  // write decodes
  wire wr_en_set;
  wire wr_en_clr;
  wire wr_pend_clr;
  wire wr_map0;
  wire wr_map1;
  wire wr_stat;
  wire wr_mask;
  wire wr_reevaluate_trigger_g;
  wire [`DCIRQ_NREG-1:0] wr_reevaluate_trigger_s;
  assign wr_en_set = wr && (addr == `DCIRQ_OFS_ENABLE_SET);
  assign wr_en_clr = wr && (addr == `DCIRQ_OFS_ENABLE_CLEAR);
  assign wr_pend_clr = wr && (addr == `DCIRQ_OFS_PENDING_CLEAR);
  assign wr_map0 = wr && (addr == `DCIRQ_OFS_REGION_MAP0);
  assign wr_map1 = wr && (addr == `DCIRQ_OFS_REGION_MAP1);
  assign wr_stat = wr && (addr == `DCIRQ_OFS_IRQ_STATUS);
  assign wr_mask = wr && (addr == `DCIRQ_OFS_IRQ_MASK);
  // every reevaluate copy decodes on address and wdata bit 0 alone, with no region gating
  assign wr_reevaluate_trigger_g = wr && (addr == `DCIRQ_OFS_REEVAL_GLOBAL) && wdata[`DCIRQ_REEVAL_BIT];
  assign wr_reevaluate_trigger_s[0] = wr && (addr == `DCIRQ_OFS_REEVAL_SHADOW0) && wdata[`DCIRQ_REEVAL_BIT];
  assign wr_reevaluate_trigger_s[1] = wr && (addr == `DCIRQ_OFS_REEVAL_SHADOW1) && wdata[`DCIRQ_REEVAL_BIT];

  // enable mask only moves through its set and clear ports
  always @(posedge clk)
  begin
    if (srst)
      enable_q <= `DCIRQ_RESET_WORD;
    else if (ce)
    begin
      if (wr_en_set)
        enable_q <= enable_q | wdata;
      else if (wr_en_clr)
        enable_q <= enable_q & ~wdata;
    end
  end

  // pending: hardware only sets, software only clears, set beats clear
  always @(posedge clk)
  begin
    if (srst)
      pending_q <= `DCIRQ_RESET_WORD;
    else if (ce)
      pending_q <= (pending_q & ~(wr_pend_clr ? wdata : 32'h00000000)) | set_req;
  end

  // region channel maps; region 0 owns every channel after reset
  always @(posedge clk)
  begin
    if (srst)
    begin
      map_q[0] <= `DCIRQ_MAP0_RESET;
      map_q[1] <= `DCIRQ_RESET_WORD;
    end
    else if (ce)
    begin
      if (wr_map0)
        map_q[0] <= wdata;
      if (wr_map1)
        map_q[1] <= wdata;
    end
  end

  // per-region pulse engine: pulse once, then wait for all pending to clear
  wire any_pend;
  assign any_pend = |pending_q;
  wire [`DCIRQ_NREG-1:0] reg_hit;
  wire [`DCIRQ_NREG-1:0] pulse_d;
  genvar r;
  generate
    for (r = 0; r < `DCIRQ_NREG; r = r + 1)
    begin : g_reg
      assign reg_hit[r] = |(pending_q & enable_q & map_q[r]);
      // reevaluate (global copy or own shadow copy) forces a fresh pulse
      assign pulse_d[r] = reg_hit[r] && (state_q[r] == ST_IDLE || wr_reevaluate_trigger_g || wr_reevaluate_trigger_s[r]);
      always @(posedge clk)
      begin
        if (srst)
          state_q[r] <= ST_IDLE;
        else if (ce)
        begin
          case (state_q[r])
            ST_IDLE:
              if (reg_hit[r])
                state_q[r] <= ST_WAIT;
            ST_WAIT:
              if (!any_pend)
                state_q[r] <= ST_IDLE;
            default:
              state_q[r] <= ST_IDLE;
          endcase
        end
      end
      always @(posedge clk)
      begin
        if (srst)
          region_irq_q[r] <= 1'b0;
        else if (ce)
          region_irq_q[r] <= pulse_d[r];
      end
    end
  endgenerate

  // sticky event status; set wins over write-one-to-clear
  wire [`DCIRQ_EV_W-1:0] ev;
  assign ev[`DCIRQ_EV_CODE_BIT] = |set_req;
  assign ev[`DCIRQ_EV_RANGE_BIT] = out_of_range;
  assign ev[`DCIRQ_EV_REEVAL_BIT] = wr_reevaluate_trigger_g | (|wr_reevaluate_trigger_s);
  always @(posedge clk)
  begin
    if (srst)
    begin
      status_q <= {`DCIRQ_EV_W{1'b0}};
      mask_q <= {`DCIRQ_EV_W{1'b0}};
    end
    else if (ce)
    begin
      status_q <= (status_q & ~(wr_stat ? wdata[`DCIRQ_EV_W-1:0] : {`DCIRQ_EV_W{1'b0}})) | ev;
      if (wr_mask)
        mask_q <= wdata[`DCIRQ_EV_W-1:0];
    end
  end

  // level interrupt, registered so the output is a flop
  always @(posedge clk)
  begin
    if (srst)
      irq_q <= 1'b0;
    else if (ce)
      irq_q <= |(status_q & mask_q);
  end

  // read mux; write-only and unmapped addresses read zero
  always @*
  begin
    rdata_d = 32'h00000000;
    case (addr)
      `DCIRQ_OFS_ENABLE_MASK: rdata_d = enable_q;
      `DCIRQ_OFS_PENDING: rdata_d = pending_q;
      `DCIRQ_OFS_REGION_MAP0: rdata_d = map_q[0];
      `DCIRQ_OFS_REGION_MAP1: rdata_d = map_q[1];
      `DCIRQ_OFS_IRQ_STATUS: rdata_d = {29'h00000000, status_q};
      `DCIRQ_OFS_IRQ_MASK: rdata_d = {29'h00000000, mask_q};
      default: rdata_d = 32'h00000000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always @(posedge clk)
  begin
    if (srst)
      rdata_q <= 32'h00000000;
    else if (ce)
      rdata_q <= rd ? rdata_d : 32'h00000000;
  end
endmodule // dcirq_top
`default_nettype wire

// File: include/dcirq_defs.vh
// constants for the dma completion interrupt unit
`ifndef DCIRQ_DEFS_VH
`define DCIRQ_DEFS_VH
`define DCIRQ_NCHAN 32
`define DCIRQ_NREG 2
`define DCIRQ_CODE_W 6
`define DCIRQ_ADDR_W 8
`define DCIRQ_OFS_ENABLE_MASK 8'h00
`define DCIRQ_OFS_ENABLE_SET 8'h04
`define DCIRQ_OFS_ENABLE_CLEAR 8'h08
`define DCIRQ_OFS_PENDING 8'h0C
`define DCIRQ_OFS_PENDING_CLEAR 8'h10
`define DCIRQ_OFS_REGION_MAP0 8'h14
`define DCIRQ_OFS_REGION_MAP1 8'h18
`define DCIRQ_OFS_REEVAL_GLOBAL 8'h1C
`define DCIRQ_OFS_REEVAL_SHADOW0 8'h20
`define DCIRQ_OFS_REEVAL_SHADOW1 8'h24
`define DCIRQ_OFS_IRQ_STATUS 8'h28
`define DCIRQ_OFS_IRQ_MASK 8'h2C
`define DCIRQ_REEVAL_BIT 0
`define DCIRQ_RESET_WORD 32'h00000000
`define DCIRQ_MAP0_RESET 32'hFFFFFFFF
`define DCIRQ_EV_CODE_BIT 0
`define DCIRQ_EV_RANGE_BIT 1
`define DCIRQ_EV_REEVAL_BIT 2
`define DCIRQ_EV_W 3
`endif

// File: verification/dcirq_chk.sv
// assertions on the ports of the dma completion interrupt unit
`timescale 1ns/10ps
`default_nettype none
module dcirq_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata_q,
  input wire logic code_valid,
  input wire logic [1:0] region_irq_q,
  input wire logic irq_q
);
  logic re0_q, re1_q, cfg_q, cfg2_q;
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  // reevaluate writes that may pulse each region, global copy hits both
  always @(posedge clk)
  begin
    re0_q <= wr && wdata[0] && (addr == 8'h1C || addr == 8'h20);
    re1_q <= wr && wdata[0] && (addr == 8'h1C || addr == 8'h24);
    // enable-set or map writes may expose waiting pending bits, pulse two cycles on
    cfg_q <= wr && (addr == 8'h04 || addr == 8'h14 || addr == 8'h18);
    cfg2_q <= cfg_q;
  end
  AST_EN_SET: assert property ((wr && addr == 8'h04) ##1 (rd && addr == 8'h00)
    |=> (rdata_q & $past(wdata, 2)) == $past(wdata, 2)) else $error("enable set lost");
  AST_EN_CLR: assert property ((wr && addr == 8'h08) ##1 (rd && addr == 8'h00)
    |=> (rdata_q & $past(wdata, 2)) == 32'h0) else $error("enable clear lost");
  AST_EN_RO: assert property ((rd && addr == 8'h00) ##1 (wr && addr == 8'h00) ##1 (rd && addr == 8'h00)
    |=> rdata_q == $past(rdata_q, 2)) else $error("enable mask written directly");
  // a set landing on the clear edge wins, so skip that case
  AST_PD_CLR: assert property ((wr && addr == 8'h10 && !$past(code_valid)) ##1 (rd && addr == 8'h0C)
    |=> (rdata_q & $past(wdata, 2)) == 32'h0) else $error("pending clear lost");
  AST_PD_KEEP: assert property ((rd && addr == 8'h0C) ##1 (rd && addr == 8'h0C)
    |=> (rdata_q & $past(rdata_q)) == $past(rdata_q)) else $error("pending bit dropped");
  AST_RG0: assert property (region_irq_q[0] |-> $past(code_valid, 3) || re0_q || cfg2_q)
    else $error("region 0 pulse without cause");
  AST_RG1: assert property (region_irq_q[1] |-> $past(code_valid, 3) || re1_q || cfg2_q)
    else $error("region 1 pulse without cause");
  AST_NO_RE: assert property ((wr && addr == 8'h20 && !wdata[0] && !$past(code_valid, 2))
    |=> !region_irq_q[0]) else $error("pulse on zero reevaluate");
  cover property (region_irq_q == 2'h3);
  cover property (irq_q);
  cover property ((rd && addr == 8'h0C) ##1 rdata_q != 32'h0);
endmodule // dcirq_chk
bind dcirq_top dcirq_chk chk_u (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata_q(rdata_q), .code_valid(code_valid), .region_irq_q(region_irq_q), .irq_q(irq_q));
`default_nettype wire

// File: verification/dcirq_tc_model.sv
// transfer controller stand-in returning completion codes
`timescale 1ns/10ps
`default_nettype none
module dcirq_tc_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [5:0] fld,
  input wire logic fin,
  input wire logic dis,
  output logic code_valid = 1'b0,
  output logic [5:0] code = 6'h00,
  output logic is_final = 1'b0,
  output logic final_irq_en = 1'b0,
  output logic inter_irq_en = 1'b0
);
  // code bus toggles when idle so a stale value is never trusted
  always @(posedge clk)
  begin
    code_valid <= go;
    code <= go ? fld : ~code;
    is_final <= fin;
    final_irq_en <= go & fin & ~dis;
    inter_irq_en <= go & ~fin & ~dis;
  end
endmodule // dcirq_tc_model
`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench for the dma completion interrupt unit
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; $display("CHECK FAILED t=%0t %h %h", $time, a, b); end end
module tb_top;
  logic clk = 0, srst = 1, wr = 0, rd = 0, go = 0, fin = 1, dis = 0, ce = 1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata_q;
  logic [5:0] fld = 6'h00, code;
  logic cv, isf, fe, ie, irq;
  logic [1:0] rg;
  int n_errors = 0, n_checks = 0, p0 = 0, p1 = 0;
  dcirq_tc_model tc_u (.clk(clk), .go(go), .fld(fld), .fin(fin), .dis(dis), .code_valid(cv), .code(code),
    .is_final(isf), .final_irq_en(fe), .inter_irq_en(ie));
  dcirq_top dut_u (.clk(clk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .code_valid(cv), .code(code), .is_final(isf), .final_irq_en(fe),
    .inter_irq_en(ie), .region_irq_q(rg), .irq_q(irq));
  initial forever #50 clk = ~clk;
  // count region pulses, each lasts one cycle
  always @(posedge clk)
  begin
    p0 += rg[0];
    p1 += rg[1];
  end
  task bus(input logic w, r, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
  endtask
  task wrt(input logic [7:0] a, input logic [31:0] d);
    bus(1, 0, a, d);
    bus(0, 0, a, d);
  endtask
  // read data stands only in the cycle after the strobe
  task rdc(input logic [7:0] a, output logic [31:0] q);
    bus(0, 1, a, 32'h0);
    bus(0, 0, a, 32'h0);
    @(negedge clk);
    q = rdata_q;
  endtask
  task send(input logic [5:0] n, input logic f, x);
    @(posedge clk);
    go <= 1;
    fld <= n;
    fin <= f;
    dis <= x;
    @(posedge clk);
    go <= 0;
  endtask
  task tally_and_finish;
    if (n_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // watchdog, the sequence needs well under 1000 cycles
  initial
  begin
    #500000;
    n_errors++;
    tally_and_finish;
  end
  initial
  begin
    logic [31:0] q, v, c;
    void'($urandom(32'h898C));
    repeat (20) @(posedge clk);
    srst <= 0;
    // reset values, write-only and unmapped places read zero
    for (int i = 0; i < 13; i++)
    begin
      rdc(8'(i * 4), q);
      `CHK(q, (i == 5) ? 32'hFFFFFFFF : 32'h0)
    end
    v = $urandom;
    c = $urandom;
    bus(1, 0, 8'h04, v);
    rdc(8'h00, q);
    `CHK(q, v)
    bus(1, 0, 8'h08, c);
    rdc(8'h00, q);
    `CHK(q, v & ~c)
    bus(0, 1, 8'h00, 32'h0);
    bus(1, 0, 8'h00, 32'hFFFFFFFF);
    rdc(8'h00, q);
    `CHK(q, v & ~c)
    // clock enable low: a write in that window must not land
    @(posedge clk);
    ce <= 0;
    wrt(8'h04, 32'hFFFFFFFF);
    ce <= 1;
    rdc(8'h00, q);
    `CHK(q, v & ~c)
    wrt(8'h04, 32'hFFFFFFFF);
    // random set of codes, odd codes final, even codes intermediate
    // bit 0 forced so the first pulse always happens
    v = ($urandom & 32'h7FFFFFFF) | 32'h00000001;
    for (int i = 0; i < 32; i++)
      if (v[i])
        send(6'(i), i[0], 1'b0);
    send(6'h28, 1, 0);
    send(6'h1F, 1, 1);
    rdc(8'h0C, q);
    `CHK(q, v)
    `CHK(p0, 1)
    `CHK(p1, 0)
    rdc(8'h28, q);
    `CHK(q, 32'h3)
    `CHK(irq, 1'b0)
    wrt(8'h2C, 32'h2);
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b1)
    wrt(8'h28, 32'h2);
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b0)
    bus(0, 1, 8'h0C, 32'h0);
    rdc(8'h0C, q);
    `CHK(q, v)
    // keep bit 0 pending so region 0 stays waiting
    c = $urandom & 32'hFFFFFFFE;
    bus(1, 0, 8'h10, c);
    rdc(8'h0C, q);
    `CHK(q, v & ~c)
    // set and clear of one bit on the same edge
    send(6'h05, 1, 0);
    wrt(8'h10, 32'h20);
    rdc(8'h0C, q);
    `CHK(q[5], 1'b1)
    `CHK(p0, 1)
    wrt(8'h10, 32'hFFFFFFFF);
    wrt(8'h18, 32'hFFFFFFFF);
    send(6'h03, 0, 0);
    repeat (5) @(negedge clk);
    `CHK(p0, 2)
    wrt(8'h20, 32'h0);
    repeat (2) @(negedge clk);
    `CHK(p0, 2)
    wrt(8'h20, 32'h1);
    wrt(8'h24, 32'h1);
    wrt(8'h1C, 32'h1);
    repeat (2) @(negedge clk);
    `CHK(p0, 4)
    `CHK(p1, 3)
    tally_and_finish;
  end
endmodule // tb_top
`default_nettype wire
